// [lels_lane_steer.sv]
// Little-endian byte-lane steering for a 64-bit or 32-bit external bus
`timescale 1ns/1ps
`default_nettype none

module lels_lane_steer #(
	parameter int ADDR_W = lels_pkg::ADDR_W
) (
	input  wire logic                     core_clk,
	input  wire logic                     sys_rst,
	input  wire logic                     bus_is_64,
	input  wire logic                     req_valid,
	input  wire lels_pkg::lels_req_t      req,
	output logic                          req_ready,
	output logic                          rsp_valid,
	output logic [lels_pkg::DATA_W-1:0]   rsp_rdata,
	output logic [ADDR_W-1:0]             ext_addr,
	output logic                          ext_write,
	output logic [lels_pkg::LANES-1:0]    lane_write_strobe,
	output logic [lels_pkg::LANES-1:0]    lane_column_strobe,
	output logic [lels_pkg::LANES-1:0]    lane_data_mask,
	output logic [lels_pkg::DATA_W-1:0]   ext_data_out,
	output logic                          ext_data_oe,
	input  wire logic [lels_pkg::DATA_W-1:0] ext_data_in
);
	import lels_pkg::*;

	// ------------------------------------------------------------
	// Decoding helpers
	// ------------------------------------------------------------

	// Lanes covered by one access of the given size, from lane 0
	function automatic logic [7:0] size_lanes(input lels_size_t sz);
		case (sz)
			LELS_BYTE: size_lanes = 8'h01;
			LELS_WORD: size_lanes = 8'h03;
			LELS_LONG: size_lanes = 8'h0F;
			default:   size_lanes = 8'hFF;
		endcase
	endfunction

	// Bit mask of the value carried by one access of the given size
	function automatic logic [63:0] size_bits(input lels_size_t sz);
		case (sz)
			LELS_BYTE: size_bits = 64'h0000_0000_0000_00FF;
			LELS_WORD: size_bits = 64'h0000_0000_0000_FFFF;
			LELS_LONG: size_bits = 64'h0000_0000_FFFF_FFFF;
			default:   size_bits = 64'hFFFF_FFFF_FFFF_FFFF;
		endcase
	endfunction

	// Offset forced to the natural alignment of the size
	function automatic logic [2:0] align_ofs(input logic [2:0] ofs, input lels_size_t sz);
		case (sz)
			LELS_BYTE: align_ofs = ofs;
			LELS_WORD: align_ofs = {ofs[2:1], 1'b0};
			LELS_LONG: align_ofs = {ofs[2], 2'h0};
			default:   align_ofs = 3'h0;
		endcase
	endfunction

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	lels_state_t         state_q, state_d;
	lels_cyc_t           cyc_q, cyc_d;
	lels_trk_t           trk_q, trk_d;
	lels_trk_t           trk1_q, trk2_q;
	lels_req_t           hold_q;
	logic                ready_q;
	logic [7:0]          wstb_q;
	logic                oe_q;
	logic                rsp_valid_q;
	logic [DATA_W-1:0]   rsp_rdata_q;
	logic [DATA_W-1:0]   acc_q;
	logic [DATA_W-1:0]   rd_s1_q, rd_s2_q;

	// ------------------------------------------------------------
	// First-cycle decode of the incoming request
	// ------------------------------------------------------------
	wire logic       take      = req_valid & ready_q;
	wire logic       split     = ~bus_is_64 & (req.size == LELS_QUAD);
	// A narrow bus cannot carry a quad at once, so each half travels as a long
	wire lels_size_t c1_size   = split ? LELS_LONG : req.size;
	// Narrow bus only sees the offset inside a four-byte group
	wire logic [2:0] c1_ofs_r  = bus_is_64 ? req.addr[2:0] : {1'b0, req.addr[1:0]};
	wire logic [2:0] c1_start  = align_ofs(c1_ofs_r, c1_size);
	wire logic [2:0] c1_aofs   = align_ofs(req.addr[2:0], req.size);
	wire logic [5:0] c1_bshift = {c1_start, 3'h0};
	// Strobes start at the first carrying lane and span only the access
	wire logic [7:0] c1_strobe = size_lanes(c1_size) << c1_start;
	// Low byte on the lowest lane used
	wire logic [63:0] c1_data  = (req.wdata & size_bits(c1_size)) << c1_bshift;
	wire logic [ADDR_W-1:0] c1_addr = {req.addr[ADDR_W-1:3], c1_aofs};

	// ------------------------------------------------------------
	// Second-cycle decode, used only by a quad on a narrow bus
	// ------------------------------------------------------------
	wire logic [ADDR_W-1:0] c2_addr = {hold_q.addr[ADDR_W-1:3], SECOND_OFS};
	wire logic [63:0] c2_data = hold_q.wdata >> HALF_SHIFT;
	wire logic [7:0]  c2_strobe = size_lanes(LELS_LONG);

	// ------------------------------------------------------------
	// Sequencer: one clock per bus cycle, no wait states
	// ------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		cyc_d   = cyc_q;
		trk_d   = trk_q;
		case (state_q)
			LELS_IDLE: begin
				cyc_d.strobe = STROBE_RST;
				trk_d.valid  = 1'b0;
				if (take) begin
					state_d      = LELS_CYC1;
					cyc_d.write  = req.write;
					cyc_d.addr   = c1_addr;
					cyc_d.strobe = c1_strobe;
					cyc_d.data   = c1_data;
					trk_d.valid  = 1'b1;
					trk_d.read   = ~req.write;
					trk_d.hi     = 1'b0;
					trk_d.last   = ~split;
					trk_d.shift  = c1_start;
					trk_d.size   = c1_size;
				end
			end
			LELS_CYC1: begin
				if (~trk_q.last) begin
					state_d      = LELS_CYC2;
					cyc_d.addr   = c2_addr;
					cyc_d.strobe = c2_strobe;
					cyc_d.data   = c2_data;
					trk_d.hi     = 1'b1;
					trk_d.last   = 1'b1;
					trk_d.shift  = 3'h0;
				end else begin
					state_d      = LELS_IDLE;
					cyc_d.strobe = STROBE_RST;
					trk_d.valid  = 1'b0;
				end
			end
			LELS_CYC2: begin
				state_d      = LELS_IDLE;
				cyc_d.strobe = STROBE_RST;
				trk_d.valid  = 1'b0;
			end
			default: begin
				state_d      = LELS_IDLE;
				cyc_d.strobe = STROBE_RST;
				trk_d.valid  = 1'b0;
			end
		endcase
	end

	// Ready returns once the sequencer is about to sit idle again
	wire logic ready_d = (state_d == LELS_IDLE);

	// Write strobe and drive enable get flops of their own, so no pin sees gated logic
	wire logic [7:0] wstb_d = cyc_d.write ? cyc_d.strobe : STROBE_RST;
	wire logic       oe_d   = cyc_d.write & (cyc_d.strobe != STROBE_RST);

	// Sequencer and bus cycle registers
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_q <= LELS_IDLE;
			cyc_q   <= '0;
			trk_q   <= '0;
			ready_q <= READY_RST;
			wstb_q  <= STROBE_RST;
			oe_q    <= 1'b0;
		end else begin
			state_q <= state_d;
			cyc_q   <= cyc_d;
			trk_q   <= trk_d;
			ready_q <= ready_d;
			wstb_q  <= wstb_d;
			oe_q    <= oe_d;
		end
	end

	// Request held for the second half of a split quad
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			hold_q <= '0;
		end else if (take) begin
			hold_q <= req;
		end
	end

	// ------------------------------------------------------------
	// Read path: pin data crosses two flops, bookkeeping keeps pace
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rd_s1_q <= DATA_RST;
			rd_s2_q <= DATA_RST;
			trk1_q  <= '0;
			trk2_q  <= '0;
		end else begin
			rd_s1_q <= ext_data_in;
			rd_s2_q <= rd_s1_q;
			trk1_q  <= trk_q;
			trk2_q  <= trk1_q;
		end
	end

	// Pick the carrying lanes only; unstrobed lanes never reach the core
	wire logic [5:0]  rd_bshift = {trk2_q.shift, 3'h0};
	wire logic [63:0] rd_lanes  = (rd_s2_q >> rd_bshift) & size_bits(trk2_q.size);
	// Second half of a narrow quad lands in the upper word
	wire logic [63:0] rd_piece  = trk2_q.hi ? (rd_lanes << HALF_SHIFT) : rd_lanes;
	wire logic [63:0] rd_merged = (trk2_q.hi ? acc_q : DATA_RST) | rd_piece;
	wire logic        rd_step   = trk2_q.valid & trk2_q.read;

	// Response assembly; a pulse per completed read
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			acc_q       <= DATA_RST;
			rsp_rdata_q <= DATA_RST;
			rsp_valid_q <= 1'b0;
		end else begin
			rsp_valid_q <= rd_step & trk2_q.last;
			if (rd_step) begin
				acc_q <= rd_merged;
			end
			if (rd_step & trk2_q.last) begin
				rsp_rdata_q <= rd_merged;
			end
		end
	end

	// ------------------------------------------------------------
	// Outputs, all straight from flops
	// ------------------------------------------------------------
	// Column strobe and mask cover reads and writes; write strobe only writes
	assign req_ready          = ready_q;
	assign rsp_valid          = rsp_valid_q;
	assign rsp_rdata          = rsp_rdata_q;
	assign ext_addr           = cyc_q.addr;
	assign ext_write          = cyc_q.write;
	assign lane_column_strobe = cyc_q.strobe;
	assign lane_data_mask     = cyc_q.strobe;
	assign lane_write_strobe  = wstb_q;
	assign ext_data_out       = cyc_q.data;
	assign ext_data_oe        = oe_q;

endmodule

`default_nettype wire

// [lels_pkg.sv]
// Shared types and constants for the little-endian lane steering block
package lels_pkg;

	// ------------------------------------------------------------
	// Widths and fixed positions
	// ------------------------------------------------------------
	localparam int          ADDR_W     = 32;
	localparam int          DATA_W     = 64;
	localparam int          LANES      = 8;
	localparam int          HALF_SHIFT = 32;
	localparam logic [2:0]  SECOND_OFS = 3'h4;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0]  STROBE_RST = 8'h00;
	localparam logic [63:0] DATA_RST   = 64'h0000_0000_0000_0000;
	localparam logic        READY_RST  = 1'b1;

	// Access size, coded as log2 of the byte count
	typedef enum logic [1:0] {
		LELS_BYTE = 2'h0,
		LELS_WORD = 2'h1,
		LELS_LONG = 2'h2,
		LELS_QUAD = 2'h3
	} lels_size_t;

	// Sequencer states, Gray along idle, first, second
	typedef enum logic [1:0] {
		LELS_IDLE = 2'h0,
		LELS_CYC1 = 2'h1,
		LELS_CYC2 = 2'h3
	} lels_state_t;

	// Request from the core side
	typedef struct packed {
		logic              write;
		lels_size_t        size;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} lels_req_t;

	// One external bus cycle
	typedef struct packed {
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic [LANES-1:0]  strobe;
		logic [DATA_W-1:0] data;
	} lels_cyc_t;

	// Bookkeeping that follows a bus cycle down the read pipeline
	typedef struct packed {
		logic       valid;
		logic       read;
		logic       hi;
		logic       last;
		logic [2:0] shift;
		lels_size_t size;
	} lels_trk_t;

endpackage

// [lels_mem_model.sv]
// External memory model answering lane strobes in the same cycle
`timescale 1ns/1ps
`default_nettype none
module lels_mem_model (
	input  wire logic        core_clk,
	input  wire logic        bus_is_64,
	input  wire logic [31:0] ext_addr,
	input  wire logic [7:0]  lane_write_strobe,
	input  wire logic [7:0]  lane_column_strobe,
	input  wire logic [63:0] ext_data_out,
	output logic      [63:0] ext_data_in
);
	logic [7:0]  mem [0:63];
	logic [63:0] last_q;

	// Byte cell behind lane k, narrow bus folds on four lanes
	function automatic logic [5:0] loc(int k);
		return bus_is_64 ? {ext_addr[5:3], 3'(k)} : {ext_addr[5:2], 2'(k)};
	endfunction

	// Unstrobed lanes show inverted junk so a stale value never matches
	always_comb begin
		for (int k = 0; k < 8; k++) begin
			ext_data_in[8*k+:8] = lane_column_strobe[k] ? mem[loc(k)] : ~last_q[8*k+:8];
		end
	end

	// Only strobed lanes are stored
	always_ff @(posedge core_clk) begin
		last_q <= ext_data_in;
		for (int k = 0; k < 8; k++) begin
			if (lane_write_strobe[k]) begin
				mem[loc(k)] <= ext_data_out[8*k+:8];
			end
		end
	end
endmodule
`default_nettype wire

// [lels_lane_steer_properties.sv]
// Port checks for the lane steering block
`timescale 1ns/1ps
`default_nettype none
module lels_steer_props #(
	parameter int ADDR_W = 32
) (
	input  wire logic                 core_clk,
	input  wire logic                 sys_rst,
	input  wire logic                 bus_is_64,
	input  wire logic                 req_valid,
	input  wire lels_pkg::lels_req_t  req,
	input  wire logic                 req_ready,
	input  wire logic                 rsp_valid,
	input  wire logic [ADDR_W-1:0]    ext_addr,
	input  wire logic                 ext_write,
	input  wire logic [7:0]           lane_write_strobe,
	input  wire logic [7:0]           lane_column_strobe,
	input  wire logic [7:0]           lane_data_mask,
	input  wire logic                 ext_data_oe
);
	import lels_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// Request accepted, and the split narrow quad case
	sequence s_take;
		req_valid && req_ready;
	endsequence
	sequence s_quad32;
		s_take ##0 (!bus_is_64 && req.size == LELS_QUAD);
	endsequence
	a_single_one_cyc: assert property (s_take ##0 (bus_is_64 || req.size != LELS_QUAD) |=>
		!req_ready ##1 req_ready) else $error("single access not one cycle");
	a_quad32_two_cyc: assert property (s_quad32 |=> (lane_column_strobe == 8'h0F)[*2]
		##1 lane_column_strobe == 8'h00) else $error("narrow quad not two cycles");
	a_quad32_addr_step: assert property (s_quad32 |=> ext_addr[2:0] == 3'h0 ##1
		(ext_addr[2:0] == 3'h4 && $stable(ext_addr[ADDR_W-1:3]))) else $error("bad second addr");
	a_byte64_lane: assert property (s_take ##0 (bus_is_64 && req.size == LELS_BYTE) |=>
		lane_column_strobe == 8'h01 << $past(req.addr[2:0])) else $error("wide byte lane");
	a_byte32_lane: assert property (s_take ##0 (!bus_is_64 && req.size == LELS_BYTE) |=>
		lane_column_strobe == 8'h01 << $past(req.addr[1:0])) else $error("narrow byte lane");
	a_quad64_all: assert property (s_take ##0 (bus_is_64 && req.size == LELS_QUAD) |=>
		lane_column_strobe == 8'hFF) else $error("wide quad lanes");
	a_long64_half: assert property (s_take ##0 (bus_is_64 && req.size == LELS_LONG) |=>
		lane_column_strobe == ($past(req.addr[2]) ? 8'hF0 : 8'h0F)) else $error("long half");
	a_strobes_agree: assert property (lane_data_mask == lane_column_strobe &&
		lane_write_strobe == (ext_write ? lane_column_strobe : 8'h00)) else $error("strobe mix");
	a_narrow_low: assert property (!bus_is_64 |-> lane_column_strobe[7:4] == 4'h0)
		else $error("upper lane on narrow bus");
	a_read_answer: assert property (s_take ##0 !req.write |-> ##[3:5] rsp_valid)
		else $error("read answer missing");
	a_oe_on_write: assert property (ext_data_oe |-> ext_write && |lane_write_strobe)
		else $error("drive outside write");
endmodule
bind lels_lane_steer lels_steer_props #(.ADDR_W(ADDR_W)) lels_steer_props_inst (.core_clk,
	.sys_rst, .bus_is_64, .req_valid, .req, .req_ready, .rsp_valid, .ext_addr, .ext_write,
	.lane_write_strobe, .lane_column_strobe, .lane_data_mask, .ext_data_oe);
`default_nettype wire

// [lels_lane_steer_tb_top.sv]
// Self-checking bench for the lane steering block
`timescale 1ns/1ps
`default_nettype none
module lels_lane_steer_tb_top;
	import lels_pkg::*;
	logic       core_clk = 0, sys_rst = 1, bus_is_64 = 1, req_valid = 0;
	lels_req_t  req = '0;
	logic       req_ready, rsp_valid, ext_write, ext_data_oe;
	logic [63:0] rsp_rdata, ext_data_out, ext_data_in;
	logic [31:0] ext_addr;
	logic [7:0] lane_write_strobe, lane_column_strobe, lane_data_mask;
	int         fails = 0, samples_checked = 0;

	lels_lane_steer lels_lane_steer_inst (.core_clk, .sys_rst, .bus_is_64, .req_valid, .req,
		.req_ready, .rsp_valid, .rsp_rdata, .ext_addr, .ext_write, .lane_write_strobe,
		.lane_column_strobe, .lane_data_mask, .ext_data_out, .ext_data_oe, .ext_data_in);
	lels_mem_model lels_mem_model_inst (.core_clk, .bus_is_64, .ext_addr, .lane_write_strobe,
		.lane_column_strobe, .ext_data_out, .ext_data_in);

	initial begin
		forever #2.5 core_clk = ~core_clk;
	end

	task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic close_out();
		if (fails == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Inputs move 1 ns after the edge, clear of sampling
	task automatic tick();
		@(posedge core_clk);
		#1;
	endtask

	// Bounded wait; running out ends the run as a failure
	task automatic wait_hi(ref logic s);
		for (int i = 0; i < 10 && s !== 1'b1; i++) tick();
		if (s !== 1'b1) begin
			fails++;
			close_out();
		end
	endtask

	// One access: strobes, address and lanes judged in the strobe cycle
	task automatic xfer(logic wr, lels_size_t sz, logic [2:0] a, logic [63:0] wd);
		logic [2:0]  al;
		logic [7:0]  st;
		logic [63:0] m, v;
		al = a & ~((3'h1 << sz) - 3'h1);
		m = (sz == LELS_QUAD) ? '1 : (64'h1 << (8 << sz)) - 64'h1;
		st = 8'(((9'h1 << (4'h1 << sz)) - 9'h1) << (bus_is_64 ? al : {1'b0, al[1:0]}));
		st &= bus_is_64 ? 8'hFF : 8'h0F;
		v = ((wd & m) << {bus_is_64 ? al : {1'b0, al[1:0]}, 3'h0});
		v &= bus_is_64 ? '1 : 64'hFFFF_FFFF;
		wait_hi(req_ready);
		req_valid = 1;
		req = '{write: wr, size: sz, addr: {29'h2, a}, wdata: wd};
		tick();
		req_valid = 0;
		check("write strobes", lane_write_strobe, wr ? st : 8'h00);
		check("column strobes", lane_column_strobe, st);
		check("data masks", lane_data_mask, st);
		check("drive", {ext_write, ext_data_oe}, {wr, wr});
		check("addr", ext_addr, {29'h2, al});
		if (wr) check("lanes", ext_data_out, v);
		if (sz == LELS_QUAD && !bus_is_64) begin
			tick();
			check("second", {lane_column_strobe, ext_addr}, {8'h0F, 29'h2, 3'h4});
			if (wr) check("high lanes", ext_data_out, {32'h0, wd[63:32]});
		end
		if (!wr) begin
			wait_hi(rsp_valid);
			check("rdata", rsp_rdata, wd & m);
		end
	endtask

	// Every size at every aligned offset of the wide bus, write then read
	task automatic t_bus64();
		bus_is_64 = 1;
		for (int s = 0; s < 4; s++) for (int a = 0; a < 8; a += 1 << s) begin
			xfer(1, lels_size_t'(s), 3'(a), 64'h8877_6655_4433_2211 ^ {8{8'(a + 16 * s)}});
			xfer(0, lels_size_t'(s), 3'(a), 64'h8877_6655_4433_2211 ^ {8{8'(a + 16 * s)}});
		end
	endtask

	// Narrow bus, including the split quad
	task automatic t_bus32();
		bus_is_64 = 0;
		for (int s = 0; s < 4; s++) for (int a = 0; a < 4; a += 1 << s) begin
			xfer(1, lels_size_t'(s), 3'(a), 64'hF0E1_D2C3_B4A5_9687 ^ {8{8'(a + 16 * s)}});
			xfer(0, lels_size_t'(s), 3'(a), 64'hF0E1_D2C3_B4A5_9687 ^ {8{8'(a + 16 * s)}});
		end
	endtask

	// Reset in the middle of a split quad write must idle the bus
	task automatic t_reset_mid();
		bus_is_64 = 0;
		req_valid = 1;
		req = '{write: 1, size: LELS_QUAD, addr: 32'h10, wdata: '1};
		tick();
		req_valid = 0;
		sys_rst = 1;
		tick();
		check("reset idle", {req_ready, lane_column_strobe, ext_data_oe},
			{1'b1, 8'h00, 1'b0});
		sys_rst = 0;
		// Low word landed before reset cut in; high word still holds the earlier quad
		xfer(0, LELS_LONG, 3'h0, 64'hFFFF_FFFF);
		xfer(0, LELS_LONG, 3'h4, 64'hC0D1_E2F3);
	endtask

	initial begin
		repeat (5) @(posedge core_clk);
		#1 sys_rst = 0;
		t_bus64();
		t_bus32();
		t_reset_mid();
		close_out();
	end
endmodule
`default_nettype wire
